// ===== rtl/mct_core.sv
// Multi-channel 16-bit timer core with APB register access
// Overview of operation
// (RULE1) Channel 1/2 status bit 7 reads direction: 1 counting up, 0 down.
// (RULE2) Status bits 5..0 read undefined, bit 6 reads 1; software writes ones.
// (RULE3) Channel 0 status bit 7 is reserved and always reads 1.
// (RULE4) Timing bit A: C copies into A on match A, or on counter clear.
// (RULE5) Timing bit B: D copies into B on match B, or on counter clear.
// (RULE6) Timing bit E: F copies into E on match E, or on clear.
// (RULE7) Software keeps timing bits zero unless the channel runs PWM.
// (RULE8) Cascaded: bits 0/1 add channel 1 pin A/B to channel 2 captures.
// (RULE9) Cascaded: bits 2/3 add channel 2 pin A/B to channel 1 captures.
// (RULE10) Software accesses counters and general registers as 16-bit words only.
// (RULE11) General registers A to D work as compare or capture registers.
// (RULE12) Channel 0 C buffers A and D buffers B.
// (RULE13) Channel 0 E and F compare; counter equal E may request A/D start. The code compares E only; F serves only as the buffer for E.
// (RULE14) Channel 0 F may act as buffer for E.
// (RULE15) Channel 5 registers support compare, capture and pulse-width measurement.
// (RULE16) Start bits 0..2 stop or run counters of channels 0..2.
// (RULE17) Software stops a counter before changing its mode or clock.
// (RULE18) A stopped counter's output pin keeps its compare level.
// (RULE19) I/O control write while stopped drives the pin's initial level at once.
// (RULE20) Channel 5 start bits 0,1,2 run counters W, V, U.
// (RULE21) Reserved upper bits of timing, capture and start registers read zero.
// (RULE22) Bus writes take effect on the next edge and win over counting.
`include "mct_defs.svh"

module mct_core
  import mct_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel 0..2 pins A/B: input, output, active-low enable (0A,0B,1A,1B,2A,2B)
  input wire logic [5:0] io_pin_in,
  output logic [5:0] io_pin_out,
  output logic [5:0] io_pin_oe_n,
  // Channel 0 capture-only pins C and D
  input wire logic [1:0] ch0_cd_pin_in,
  // Channel 5 inputs and compare pulses, index 0 W, 1 V, 2 U
  input wire logic [2:0] ch5_pin_in,
  output logic [2:0] ch5_match,
  // A/D converter start request
  output logic adc_start_req
);

  mct_state_t q_r;
  mct_state_t q_nxt;

  logic [29:0] ix;
  logic wr;
  logic rd_setup;
  logic hit;
  logic [31:0] rd_val;
  logic [10:0] pins;
  logic [10:0] rise;
  logic [10:0] fall;
  logic [2:0] match_a;
  logic [2:0] match_b;
  logic [2:0] clr;
  logic match_e;
  logic [7:0] cap_ev;

  assign ix = paddr[31:2];
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  // Inputs in order 0A,0B,0C,0D,1A,1B,2A,2B,5W,5V,5U
  assign pins = {ch5_pin_in, io_pin_in[5:2], ch0_cd_pin_in, io_pin_in[1:0]};
  assign rise = pins & ~q_r.pin_prev;
  assign fall = ~pins & q_r.pin_prev;

  always_comb begin
    int inp;
    int o;
    q_nxt = q_r;
    inp = 0;
    o = 0;
    hit = 1'b0;
    rd_val = 32'h0000_0000;
    match_a = 3'h0;
    match_b = 3'h0;
    clr = 3'h0;
    cap_ev = 8'h00;
    q_nxt.adc_req = 1'b0;
    q_nxt.match5 = 3'h0;
    q_nxt.pin_prev = pins;

    // Compare and capture events of channels 0..2
    for (int ch = 0; ch < 3; ch++) begin
      for (int ab = 0; ab < 2; ab++) begin
        inp = ch * 2 + ab + ((ch == 0) ? 0 : 2);
        // RULE11 capture on pin edge
        cap_ev[inp] = q_r.ctrl[`MCT_CTRL_CAP + inp] & rise[inp];
      end
      match_a[ch] = q_r.run[ch] & ~q_r.ctrl[`MCT_CTRL_CAP + ch * 2 + ((ch == 0) ? 0 : 2)] &
                    (q_r.cnt[ch] == q_r.grab[ch][0]);
      match_b[ch] = q_r.run[ch] & ~q_r.ctrl[`MCT_CTRL_CAP + ch * 2 + ((ch == 0) ? 1 : 3)] &
                    (q_r.cnt[ch] == q_r.grab[ch][1]);
      clr[ch] = match_a[ch] & q_r.ctrl[`MCT_CTRL_CLR_A + ch];
    end
    cap_ev[2] = q_r.ctrl[`MCT_CTRL_CAP + 2] & rise[2];
    cap_ev[3] = q_r.ctrl[`MCT_CTRL_CAP + 3] & rise[3];
    if (q_r.ctrl[`MCT_CTRL_CASCADE]) begin
      // RULE8 channel 1 pins into channel 2 captures
      cap_ev[6] = cap_ev[6] | (q_r.ctrl[`MCT_CTRL_CAP + 6] & q_r.ccr[0] & rise[4]);
      cap_ev[7] = cap_ev[7] | (q_r.ctrl[`MCT_CTRL_CAP + 7] & q_r.ccr[1] & rise[5]);
      // RULE9 channel 2 pins into channel 1 captures
      cap_ev[4] = cap_ev[4] | (q_r.ctrl[`MCT_CTRL_CAP + 4] & q_r.ccr[2] & rise[6]);
      cap_ev[5] = cap_ev[5] | (q_r.ctrl[`MCT_CTRL_CAP + 5] & q_r.ccr[3] & rise[7]);
    end
    match_e = q_r.run[0] & (q_r.cnt[0] == q_r.gr0x[2]);

    for (int ch = 0; ch < 3; ch++) begin
      // RULE16 count only while the start bit is set
      if (q_r.run[ch]) begin
        if (clr[ch]) begin
          q_nxt.cnt[ch] = 16'h0000;
        end else if ((ch == 1 && q_r.ctrl[`MCT_CTRL_DOWN1]) ||
                     (ch == 2 && q_r.ctrl[`MCT_CTRL_DOWN2])) begin
          q_nxt.cnt[ch] = q_r.cnt[ch] - 16'h0001;
        end else begin
          q_nxt.cnt[ch] = q_r.cnt[ch] + 16'h0001;
        end
      end
      for (int ab = 0; ab < 2; ab++) begin
        inp = ch * 2 + ab + ((ch == 0) ? 0 : 2);
        o = ch * 2 + ab;
        if (cap_ev[inp]) begin
          q_nxt.grab[ch][ab] = q_r.cnt[ch];
        end
        // RULE18 here the pin moves only on a match, so a stopped counter holds it
        if (q_r.ioctl[`MCT_IOCTL_TOG + o] && ((ab == 0) ? match_a[ch] : match_b[ch])) begin
          q_nxt.pin_out[o] = ~q_r.pin_out[o];
        end
      end
    end
    for (int cd = 0; cd < 2; cd++) begin
      if (cap_ev[2 + cd]) begin
        q_nxt.gr0x[cd] = q_r.cnt[0];
      end
    end

    // RULE12 C buffers A and D buffers B
    if (q_r.ctrl[`MCT_CTRL_BUF_AB]) begin
      // RULE4 copy C to A on match A or on clear
      if (q_r.xfer_sel[0] ? clr[0] : match_a[0]) begin
        q_nxt.grab[0][0] = q_r.gr0x[0];
      end
      // RULE5 copy D to B on match B or on clear
      if (q_r.xfer_sel[1] ? clr[0] : match_b[0]) begin
        q_nxt.grab[0][1] = q_r.gr0x[1];
      end
    end
    // RULE14 F buffers E
    if (q_r.ctrl[`MCT_CTRL_BUF_E]) begin
      // RULE6 copy F to E on match E or on clear
      if (q_r.xfer_sel[2] ? clr[0] : match_e) begin
        q_nxt.gr0x[2] = q_r.gr0x[3];
      end
    end
    // RULE13 A/D start request on counter equal E
    q_nxt.adc_req = match_e & q_r.ctrl[`MCT_CTRL_ADC_EN];

    // RULE15 channel 5: compare, capture or pulse-width measurement
    for (int k = 0; k < 3; k++) begin
      // RULE20 start bits 0..2 run W, V, U
      if (q_r.ctrl[`MCT_CTRL_PW5 + k]) begin
        // Width counted while the pin is high, taken and restarted at its fall
        if (fall[8 + k]) begin
          q_nxt.gr5[k] = q_r.cnt5[k];
          q_nxt.cnt5[k] = 16'h0000;
        end else if (q_r.run5[k] && pins[8 + k]) begin
          q_nxt.cnt5[k] = q_r.cnt5[k] + 16'h0001;
        end
      end else begin
        if (q_r.run5[k]) begin
          q_nxt.cnt5[k] = q_r.cnt5[k] + 16'h0001;
        end
        if (q_r.ctrl[`MCT_CTRL_CAP5 + k]) begin
          if (rise[8 + k]) begin
            q_nxt.gr5[k] = q_r.cnt5[k];
          end
        end else begin
          q_nxt.match5[k] = q_r.run5[k] & (q_r.cnt5[k] == q_r.gr5[k]);
        end
      end
    end

    // Register decode; a bus write is applied last so it wins over counting
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (ix == `MCT_IX_START) begin
      hit = 1'b1;
      // RULE21 upper bits read zero
      rd_val = {29'h0, q_r.run};
      if (wr) begin
        // RULE22 write lands on the access edge
        q_nxt.run = pwdata[2:0];
      end
    end else if (ix == `MCT_IX_CH5_START) begin
      hit = 1'b1;
      rd_val = {29'h0, q_r.run5};
      if (wr) begin
        q_nxt.run5 = pwdata[2:0];
      end
    end else if (ix == `MCT_IX_XFER_SEL) begin
      hit = 1'b1;
      rd_val = {29'h0, q_r.xfer_sel};
      if (wr) begin
        q_nxt.xfer_sel = pwdata[2:0];
      end
    end else if (ix == `MCT_IX_CCR) begin
      hit = 1'b1;
      rd_val = {28'h0, q_r.ccr};
      if (wr) begin
        q_nxt.ccr = pwdata[3:0];
      end
    end else if (ix == `MCT_IX_CTRL) begin
      hit = 1'b1;
      rd_val = {9'h0, q_r.ctrl};
      if (wr) begin
        q_nxt.ctrl = pwdata[`MCT_CTRL_W-1:0];
      end
    end else if (ix == `MCT_IX_IOCTL) begin
      hit = 1'b1;
      rd_val = {20'h0, q_r.ioctl};
      if (wr) begin
        q_nxt.ioctl = pwdata[`MCT_IOCTL_W-1:0];
        for (int p = 0; p < 6; p++) begin
          // RULE19 stopped channel takes the initial level at once
          if (!q_r.run[p / 2]) begin
            q_nxt.pin_out[p] = pwdata[`MCT_IOCTL_INIT + p];
          end
        end
      end
    end else if (ix == `MCT_IX_CH0_STAT) begin
      hit = 1'b1;
      // RULE3 direction position reads 1
      // RULE2 reserved bits read ones, writes ignored
      rd_val = {24'h0, `MCT_CH0_DIR_RSVD, `MCT_STAT_RSVD};
    end else if (ix == `MCT_IX_CH1_STAT) begin
      hit = 1'b1;
      // RULE1 direction flag, 1 while counting up
      rd_val = {24'h0, ~q_r.ctrl[`MCT_CTRL_DOWN1], `MCT_STAT_RSVD};
    end else if (ix == `MCT_IX_CH2_STAT) begin
      hit = 1'b1;
      rd_val = {24'h0, ~q_r.ctrl[`MCT_CTRL_DOWN2], `MCT_STAT_RSVD};
    end else if (ix == `MCT_IX_CH0_CNT) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.cnt[0]};
      if (wr) begin
        q_nxt.cnt[0] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH1_CNT) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.cnt[1]};
      if (wr) begin
        q_nxt.cnt[1] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH2_CNT) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.cnt[2]};
      if (wr) begin
        q_nxt.cnt[2] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH0_GRA || ix == `MCT_IX_CH0_GRB) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.grab[0][ix[1]]};
      if (wr) begin
        q_nxt.grab[0][ix[1]] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH1_GRA || ix == `MCT_IX_CH1_GRB) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.grab[1][ix[1]]};
      if (wr) begin
        q_nxt.grab[1][ix[1]] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH2_GRA || ix == `MCT_IX_CH2_GRB) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.grab[2][ix[1]]};
      if (wr) begin
        q_nxt.grab[2][ix[1]] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH0_GRC || ix == `MCT_IX_CH0_GRD) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.gr0x[ix[1]]};
      if (wr) begin
        q_nxt.gr0x[ix[1]] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH0_GRE || ix == `MCT_IX_CH0_GRF) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.gr0x[{1'b1, ix[1]}]};
      if (wr) begin
        q_nxt.gr0x[{1'b1, ix[1]}] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH5_CNTW || ix == `MCT_IX_CH5_CNTV ||
                 ix == `MCT_IX_CH5_CNTU) begin
      hit = 1'b1;
      // Slots 0 W, 1 V, 2 U from index bits 5:4
      rd_val = {16'h0, q_r.cnt5[2'd2 - ix[5:4]]};
      if (wr) begin
        q_nxt.cnt5[2'd2 - ix[5:4]] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH5_GRU || ix == `MCT_IX_CH5_GRV) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.gr5[2'd2 - ix[5:4]]};
      if (wr) begin
        q_nxt.gr5[2'd2 - ix[5:4]] = pwdata[15:0];
      end
    end else if (ix == `MCT_IX_CH5_GRW) begin
      hit = 1'b1;
      rd_val = {16'h0, q_r.gr5[0]};
      if (wr) begin
        q_nxt.gr5[0] = pwdata[15:0];
      end
    end

    // Read data and error are latched in the setup cycle, shown in access
    if (rd_setup) begin
      q_nxt.prdata = pwrite ? 32'h0000_0000 : rd_val;
      q_nxt.pslverr = ~hit;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = q_r.prdata;
  assign pslverr = q_r.pslverr;
  assign io_pin_out = q_r.pin_out;
  assign io_pin_oe_n = {q_r.ctrl[`MCT_CTRL_CAP + 7 -: 4], q_r.ctrl[`MCT_CTRL_CAP + 1 -: 2]};
  assign ch5_match = q_r.match5;
  assign adc_start_req = q_r.adc_req;

  default clocking mct_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_ch0_dir_ones: assert property (rd_setup && !pwrite && ix == `MCT_IX_CH0_STAT && // RULE3
    paddr[1:0] == 2'b00 |=> prdata[7:0] == 8'hff)
    else $error("channel 0 status did not read all ones");
  a_ch1_dir_flag: assert property (rd_setup && !pwrite && ix == `MCT_IX_CH1_STAT && // RULE1
    paddr[1:0] == 2'b00 |=> prdata[7] == !$past(q_r.ctrl[`MCT_CTRL_DOWN1]) && prdata[6])
    else $error("channel 1 direction flag wrong");
  a_xfer_rsvd_zero: assert property (rd_setup && !pwrite && ix == `MCT_IX_XFER_SEL && // RULE21
    paddr[1:0] == 2'b00 |=> prdata[31:3] == 29'h0)
    else $error("timing register upper bits not zero");
  a_stop_hold_pin: assert property (!q_r.run[1] && !(wr && ix == `MCT_IX_IOCTL) // RULE18
    |=> io_pin_out[3:2] == $past(io_pin_out[3:2]))
    else $error("stopped channel 1 pin changed");
  a_ioctl_init_lvl: assert property (wr && ix == `MCT_IX_IOCTL && paddr[1:0] == 2'b00 && // RULE19
    !q_r.run[0] |=> io_pin_out[1:0] == $past(pwdata[1:0]))
    else $error("initial level not driven on stopped channel 0");
  a_stopped_no_cnt: assert property (!q_r.run[2] && !(wr && ix == `MCT_IX_CH2_CNT) // RULE16
    |=> q_r.cnt[2] == $past(q_r.cnt[2]))
    else $error("stopped channel 2 counter moved");
  a_buf_a_match: assert property (q_r.ctrl[`MCT_CTRL_BUF_AB] && !q_r.xfer_sel[0] && // RULE4
    match_a[0] && !wr |=> q_r.grab[0][0] == $past(q_r.gr0x[0]))
    else $error("buffer C not moved to A on match");
  a_buf_e_clear: assert property (q_r.ctrl[`MCT_CTRL_BUF_E] && q_r.xfer_sel[2] && clr[0] // RULE6
    && !wr |=> q_r.gr0x[2] == $past(q_r.gr0x[3]) && q_r.cnt[0] == 16'h0000)
    else $error("buffer F not moved to E on clear");
  a_adc_on_match: assert property (match_e && q_r.ctrl[`MCT_CTRL_ADC_EN] // RULE13
    |=> adc_start_req ##1 (!adc_start_req || $past(match_e)))
    else $error("A/D start request missing after match E");
  a_cascade_cap: assert property (q_r.ctrl[`MCT_CTRL_CASCADE] && q_r.ccr[2] && // RULE9
    q_r.ctrl[`MCT_CTRL_CAP + 4] && rise[6] && !wr |=> q_r.grab[1][0] == $past(q_r.cnt[1]))
    else $error("channel 2 pin A did not capture into channel 1");
  a_ch5_w_stop: assert property (!q_r.run5[0] && !q_r.ctrl[`MCT_CTRL_PW5] && !wr // RULE20
    |=> q_r.cnt5[0] == $past(q_r.cnt5[0]))
    else $error("stopped channel 5 W counter moved");
  a_write_wins: assert property (wr && ix == `MCT_IX_CH0_CNT && paddr[1:0] == 2'b00 // RULE22
    |=> q_r.cnt[0] == $past(pwdata[15:0]))
    else $error("counter write lost against counting");

  c_adc_req: cover property (adc_start_req);
  c_buf_xfer: cover property (q_r.ctrl[`MCT_CTRL_BUF_AB] && match_a[0]);
  c_cascade_cap: cover property (q_r.ctrl[`MCT_CTRL_CASCADE] && |cap_ev[7:4]);
  c_pulse_width: cover property (q_r.ctrl[`MCT_CTRL_PW5] && fall[8]);

endmodule : mct_core

// ===== rtl/mct_defs.svh
// Register indices, field positions and fixed read values for the timer core
`ifndef MCT_DEFS_SVH
`define MCT_DEFS_SVH

// Register indices (byte address is four times the index)
`define MCT_IX_START 30'h0008_8680
`define MCT_IX_CTRL 30'h0008_86f0
`define MCT_IX_IOCTL 30'h0008_86f4
`define MCT_IX_CH0_STAT 30'h0008_8705
`define MCT_IX_CH0_CNT 30'h0008_8706
`define MCT_IX_CH0_GRA 30'h0008_8708
`define MCT_IX_CH0_GRB 30'h0008_870a
`define MCT_IX_CH0_GRC 30'h0008_870c
`define MCT_IX_CH0_GRD 30'h0008_870e
`define MCT_IX_CH0_GRE 30'h0008_8720
`define MCT_IX_CH0_GRF 30'h0008_8722
`define MCT_IX_XFER_SEL 30'h0008_8726
`define MCT_IX_CH1_STAT 30'h0008_8785
`define MCT_IX_CH1_CNT 30'h0008_8786
`define MCT_IX_CH1_GRA 30'h0008_8788
`define MCT_IX_CH1_GRB 30'h0008_878a
`define MCT_IX_CCR 30'h0008_8790
`define MCT_IX_CH2_STAT 30'h0008_8805
`define MCT_IX_CH2_CNT 30'h0008_8806
`define MCT_IX_CH2_GRA 30'h0008_8808
`define MCT_IX_CH2_GRB 30'h0008_880a
`define MCT_IX_CH5_GRW 30'h0008_8842
`define MCT_IX_CH5_CNTU 30'h0008_8880
`define MCT_IX_CH5_GRU 30'h0008_8882
`define MCT_IX_CH5_CNTV 30'h0008_8890
`define MCT_IX_CH5_GRV 30'h0008_8892
`define MCT_IX_CH5_CNTW 30'h0008_88a0
`define MCT_IX_CH5_START 30'h0008_88b4

// Control register fields
`define MCT_CTRL_BUF_AB 0
`define MCT_CTRL_BUF_E 1
`define MCT_CTRL_CLR_A 2
`define MCT_CTRL_DOWN1 5
`define MCT_CTRL_DOWN2 6
`define MCT_CTRL_CASCADE 7
`define MCT_CTRL_CAP 8
`define MCT_CTRL_CAP5 16
`define MCT_CTRL_PW5 19
`define MCT_CTRL_ADC_EN 22
`define MCT_CTRL_W 23

// I/O control fields: initial level per pin, toggle enable per pin
`define MCT_IOCTL_INIT 0
`define MCT_IOCTL_TOG 6
`define MCT_IOCTL_W 12

// Status register reserved bits b6..b0 read back as ones
`define MCT_STAT_RSVD 7'h7f
`define MCT_CH0_DIR_RSVD 1'h1

`endif

// ===== rtl/mct_pkg.sv
// Types shared by the timer core
package mct_pkg;

  typedef logic [15:0] mct_word_t;

  typedef struct packed {
    logic [2:0] run;
    logic [2:0] run5;
    logic [2:0] xfer_sel;
    logic [3:0] ccr;
    logic [22:0] ctrl;
    logic [11:0] ioctl;
    mct_word_t [2:0] cnt;
    mct_word_t [2:0][1:0] grab;
    mct_word_t [3:0] gr0x;
    mct_word_t [2:0] cnt5;
    mct_word_t [2:0] gr5;
    logic [5:0] pin_out;
    logic [10:0] pin_prev;
    logic [2:0] match5;
    logic adc_req;
    logic [31:0] prdata;
    logic pslverr;
  } mct_state_t;

endpackage : mct_pkg

// ===== dv/mct_tb.sv
// Self-checking bench for the timer core register block
`include "mct_defs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, adc_start_req;
  logic [31:0] paddr, pwdata, prdata, rdv;
  logic [5:0] io_pin_in, io_pin_out, io_pin_oe_n;
  logic [1:0] ch0_cd_pin_in;
  logic [2:0] ch5_pin_in, ch5_match;
  int bad_count, cmp_count, adc_n;
  int m5 [3];
  int m5s [3];
  logic [29:0] cnt_ix [6];
  logic [29:0] cap_ix [4];
  logic [29:0] rsv_ix [4];

  mct_core mct_core_inst (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe_n(io_pin_oe_n),
    .ch0_cd_pin_in(ch0_cd_pin_in), .ch5_pin_in(ch5_pin_in), .ch5_match(ch5_match),
    .adc_start_req(adc_start_req)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Pulse counters, so the main sequence only compares snapshots
  always @(posedge clock) begin
    if (adc_start_req === 1'b1)
      adc_n <= adc_n + 1;
    for (int b = 0; b < 3; b++)
      if (ch5_match[b] === 1'b1)
        m5[b] <= m5[b] + 1;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic apb(input logic wr_en, input logic [29:0] ix, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      bad_count++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      finish_test();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [29:0] ix, input logic [31:0] d);
    apb(1'b1, ix, d);
    `CHK("write error", 1'b0, err)
  endtask : wr

  task automatic rd(input logic [29:0] ix, input logic [31:0] ex);
    apb(1'b0, ix, 32'h0);
    `CHK("read error", 1'b0, err)
    `CHK("read data", ex, rdv)
  endtask : rd

  task automatic pulse(input int p);
    io_pin_in[p] <= 1'b1;
    repeat (3) @(posedge clock);
    io_pin_in[p] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : pulse

  initial begin
    logic keep;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    io_pin_in = 6'h00;
    ch0_cd_pin_in = 2'h0;
    ch5_pin_in = 3'h0;
    bad_count = 0;
    cmp_count = 0;
    adc_n = 0;
    m5 = '{0, 0, 0};
    cnt_ix = '{`MCT_IX_CH0_CNT, `MCT_IX_CH1_CNT, `MCT_IX_CH2_CNT,
               `MCT_IX_CH5_CNTW, `MCT_IX_CH5_CNTV, `MCT_IX_CH5_CNTU};
    cap_ix = '{`MCT_IX_CH2_GRA, `MCT_IX_CH2_GRB, `MCT_IX_CH1_GRA, `MCT_IX_CH1_GRB};
    rsv_ix = '{`MCT_IX_START, `MCT_IX_CH5_START, `MCT_IX_XFER_SEL, `MCT_IX_CCR};
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    `CHK("pin enables after reset", 6'h00, io_pin_oe_n)
    rd(`MCT_IX_CH0_STAT, 32'hff);
    wr(`MCT_IX_CH0_STAT, 32'h0);
    rd(`MCT_IX_CH0_STAT, 32'hff);
    rd(`MCT_IX_CH1_STAT, 32'hff);
    wr(`MCT_IX_CTRL, 32'h20);
    rd(`MCT_IX_CH1_STAT, 32'h7f);
    rd(`MCT_IX_CH2_STAT, 32'hff);
    wr(`MCT_IX_CTRL, 32'h40);
    rd(`MCT_IX_CH2_STAT, 32'h7f);
    rd(`MCT_IX_CH1_STAT, 32'hff);
    wr(`MCT_IX_CTRL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(rsv_ix[k], 32'hff);
      rd(rsv_ix[k], (k == 3) ? 32'h0f : 32'h07);
      wr(rsv_ix[k], 32'h0);
    end
    // Unmapped place must be refused
    apb(1'b0, 30'h0008_8681, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rdv)
    wr(`MCT_IX_CH5_GRW, 32'h4);
    wr(`MCT_IX_CH5_GRV, 32'h4);
    wr(`MCT_IX_CH5_GRU, 32'h4);
    // Each start bit runs exactly its own counter
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 6; j++)
        wr(cnt_ix[j], 32'h0);
      m5s = m5;
      wr((i < 3) ? `MCT_IX_START : `MCT_IX_CH5_START, 32'h1 << (i % 3));
      repeat (10) @(posedge clock);
      wr((i < 3) ? `MCT_IX_START : `MCT_IX_CH5_START, 32'h0);
      for (int j = 0; j < 6; j++) begin
        apb(1'b0, cnt_ix[j], 32'h0);
        `CHK("counter runs", (i == j), (rdv != 32'h0))
        if (i > 2 && j < 3)
          `CHK("ch5 match", (j == i - 3), (m5[j] != m5s[j]))
      end
    end
    // Buffer pairs with clear on match A and A/D start enabled
    wr(`MCT_IX_CTRL, 32'h0040_0007);
    wr(`MCT_IX_CH0_GRA, 32'h40);
    wr(`MCT_IX_CH0_GRC, 32'h50);
    wr(`MCT_IX_CH0_GRB, 32'h10);
    wr(`MCT_IX_CH0_GRD, 32'h30);
    wr(`MCT_IX_CH0_GRE, 32'h10);
    wr(`MCT_IX_CH0_GRF, 32'h30);
    wr(`MCT_IX_CH0_CNT, 32'h0);
    adc_n = 0;
    wr(`MCT_IX_START, 32'h1);
    repeat (30) @(posedge clock);
    wr(`MCT_IX_START, 32'h0);
    rd(`MCT_IX_CH0_GRB, 32'h30);
    rd(`MCT_IX_CH0_GRE, 32'h30);
    `CHK("adc requests", 1, adc_n)
    wr(`MCT_IX_CH0_GRB, 32'h10);
    wr(`MCT_IX_CH0_GRE, 32'h10);
    wr(`MCT_IX_CH0_CNT, 32'h0);
    wr(`MCT_IX_XFER_SEL, 32'h7);
    wr(`MCT_IX_START, 32'h1);
    repeat (30) @(posedge clock);
    wr(`MCT_IX_START, 32'h0);
    rd(`MCT_IX_CH0_GRA, 32'h40);
    rd(`MCT_IX_CH0_GRB, 32'h10);
    rd(`MCT_IX_CH0_GRE, 32'h10);
    wr(`MCT_IX_START, 32'h1);
    repeat (40) @(posedge clock);
    wr(`MCT_IX_START, 32'h0);
    rd(`MCT_IX_CH0_GRA, 32'h50);
    rd(`MCT_IX_CH0_GRB, 32'h30);
    rd(`MCT_IX_CH0_GRE, 32'h30);
    // timing bits back to zero outside buffered use
    wr(`MCT_IX_XFER_SEL, 32'h0);
    wr(`MCT_IX_IOCTL, 32'h040);
    `CHK("pin 0A initial", 1'b0, io_pin_out[0])
    wr(`MCT_IX_IOCTL, 32'h041);
    `CHK("pin 0A initial", 1'b1, io_pin_out[0])
    wr(`MCT_IX_START, 32'h1);
    repeat (100) @(posedge clock);
    wr(`MCT_IX_START, 32'h0);
    keep = io_pin_out[0];
    repeat (20) @(posedge clock);
    `CHK("pin 0A toggled once", 1'b0, keep)
    `CHK("pin 0A held", keep, io_pin_out[0])
    // Cascade on, channel 1 and 2 pins in capture mode
    wr(`MCT_IX_CTRL, 32'h0000_f080);
    `CHK("capture pins released", 6'h3c, io_pin_oe_n)
    for (int k = 0; k < 4; k++) begin
      wr(`MCT_IX_CH1_CNT, 32'h0a00 + k);
      wr(`MCT_IX_CH2_CNT, 32'h0a00 + k);
      wr(`MCT_IX_CCR, 32'h1 << k);
      pulse(2 + k);
      rd(cap_ix[k], 32'h0a00 + k);
      wr(`MCT_IX_CH1_CNT, 32'h0b00);
      wr(`MCT_IX_CH2_CNT, 32'h0b00);
      wr(`MCT_IX_CCR, 32'h0);
      pulse(2 + k);
      rd(cap_ix[k], 32'h0a00 + k);
    end
    // Channel 5 W measures high width, V and channel 0 C capture while stopped
    wr(`MCT_IX_CTRL, 32'h000a_0400);
    wr(`MCT_IX_CH0_CNT, 32'h0c0c);
    wr(`MCT_IX_CH5_CNTV, 32'h0123);
    wr(`MCT_IX_CH5_CNTW, 32'h0);
    wr(`MCT_IX_CH5_START, 32'h1);
    ch5_pin_in <= 3'h3;
    ch0_cd_pin_in <= 2'h1;
    repeat (20) @(posedge clock);
    ch5_pin_in <= 3'h0;
    ch0_cd_pin_in <= 2'h0;
    repeat (2) @(posedge clock);
    wr(`MCT_IX_CH5_START, 32'h0);
    rd(`MCT_IX_CH5_GRW, 32'h14);
    rd(`MCT_IX_CH5_GRV, 32'h0123);
    rd(`MCT_IX_CH0_GRC, 32'h0c0c);
    finish_test();
  end
endmodule : tb
